/* File: usbc_cfg_ep.sv */
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "usbc_params.svh"

// Functional notes
// - Bits 31..8 and unimplemented bits of all registers read zero.
// - Config bit 7 turns the eye-pattern test on or off.
// - Config bit 6 enables the drive-enable monitor output; clear keeps it inactive.
// - Config bit 4 halts the module while the device is idle.
// - Config bit 0 suspends the module automatically in sleep.
// - Without auto suspend, only the software suspend bit suspends and stops 48 MHz.
// - Host mode: endpoint 0 bit 7 selects direct low-speed, else hub preamble.
// - Host mode: endpoint 0 bit 6 clear retries NAKed transactions in hardware.
// - With transmit and receive enabled, bit 4 set rejects SETUP transfers.
// - Bit 4 is ignored unless transmit and receive are both enabled.
// - Endpoint bit 3 enables reception.
// - Endpoint bit 2 enables transmission.
// - Endpoint bit 1 reports whether the endpoint was stalled.
// - Endpoint bit 0 enables handshakes; clear suppresses them.
module usbc_cfg_ep
	import usbc_pkg::*;
#(
	parameter int NUM_EP = 16,
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	// AXI4-Lite write address
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	// AXI4-Lite write data
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	input  wire usbc_word_t        s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	// AXI4-Lite write response
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	output logic [1:0]             s_axi_bresp_o,
	// AXI4-Lite read address
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
	// AXI4-Lite read data
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	output usbc_word_t             s_axi_rdata_o,
	output logic [1:0]             s_axi_rresp_o,
	// Power manager and engine status
	input  wire logic              idle_i,
	input  wire logic              sleep_i,
	input  wire logic              host_mode_i,
	input  wire logic              phy_drive_i,
	input  wire logic [NUM_EP-1:0] stall_sent_i,
	// Module control
	output logic                   eye_pattern_test_o,
	output logic                   drive_enable_monitor_o,
	output logic                   module_halt_o,
	output logic                   suspend_o,
	output logic                   clk48_enable_o,
	// Host mode endpoint 0 control
	output logic                   lowspeed_direct_o,
	output logic                   preamble_needed_o,
	output logic                   nak_retry_o,
	// Per endpoint control
	output logic [NUM_EP-1:0]      ep_rx_en_o,
	output logic [NUM_EP-1:0]      ep_tx_en_o,
	output logic [NUM_EP-1:0]      ep_setup_ok_o,
	output logic [NUM_EP-1:0]      ep_handshake_en_o
);

	// ------------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------------
	if (NUM_EP < 1 || NUM_EP > 16 || ADDR_W < 8) begin : g_bad_param
		$error("usbc_cfg_ep: NUM_EP must be 1..16 and ADDR_W at least 8");
	end

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	usbc_reg8_t              cfg;
	usbc_reg8_t              pwr;
	usbc_reg8_t              ep_ctl [NUM_EP];
	logic [NUM_EP-1:0]       ep_wr;
	logic [ADDR_W-1:0]       aw_addr;
	logic                    aw_full;
	usbc_reg8_t              w_byte;
	logic                    w_lane0;
	logic                    w_full;
	logic                    wr_go;
	usbc_sel_t               wr_sel;
	logic [`USBC_EP_IDX_W-1:0] wr_idx;
	usbc_sel_t               rd_sel;
	logic [`USBC_EP_IDX_W-1:0] rd_idx;
	usbc_reg8_t              rd_byte;
	logic                    next_suspend;

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	function automatic usbc_sel_t decode(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] base;
		logic [ADDR_W-1:0] span;
		base = ADDR_W'(`USBC_OFS_EP_BASE);
		span = ADDR_W'(NUM_EP) << `USBC_EP_IDX_LSB;
		if (addr[1:0] != 2'b00) begin
			decode = USBC_SEL_NONE;
		end else if (addr == ADDR_W'(`USBC_OFS_CFG)) begin
			decode = USBC_SEL_CFG;
		end else if (addr == ADDR_W'(`USBC_OFS_PWR)) begin
			decode = USBC_SEL_PWR;
		end else if (addr >= base && addr < base + span) begin
			decode = USBC_SEL_EP;
		end else begin
			decode = USBC_SEL_NONE;
		end
	endfunction

	assign wr_sel = decode(aw_addr);
	assign rd_sel = decode(s_axi_araddr_i);
	assign wr_idx = aw_addr[`USBC_EP_IDX_LSB +: `USBC_EP_IDX_W];
	assign rd_idx = s_axi_araddr_i[`USBC_EP_IDX_LSB +: `USBC_EP_IDX_W];

	// ------------------------------------------------------------------------
	// Write channels, taken in either order
	// ------------------------------------------------------------------------
	assign s_axi_awready_o = ce_i && !aw_full && !s_axi_bvalid_o;
	assign s_axi_wready_o  = ce_i && !w_full && !s_axi_bvalid_o;
	assign wr_go           = ce_i && aw_full && w_full && !s_axi_bvalid_o;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_full <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr_i;
		end else if (wr_go) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_full  <= 1'b0;
			w_byte  <= '0;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_full  <= 1'b1;
			w_byte  <= s_axi_wdata_i[7:0];
			w_lane0 <= s_axi_wstrb_i[0];
		end else if (wr_go) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `USBC_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (wr_sel == USBC_SEL_NONE) ? `USBC_RESP_SLVERR
				: `USBC_RESP_OKAY;
		end else if (ce_i && s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Configuration and power registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg <= `USBC_CFG_RESET;
		end else if (wr_go && w_lane0 && wr_sel == USBC_SEL_CFG) begin
			cfg <= w_byte & `USBC_CFG_WMASK;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr <= `USBC_PWR_RESET;
		end else if (wr_go && w_lane0 && wr_sel == USBC_SEL_PWR) begin
			pwr <= w_byte & `USBC_PWR_WMASK;
		end
	end

	// ------------------------------------------------------------------------
	// Endpoint registers
	// ------------------------------------------------------------------------
	for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
		assign ep_wr[i] = wr_go && w_lane0 && wr_sel == USBC_SEL_EP &&
			wr_idx == `USBC_EP_IDX_W'(i);

		usbc_ep_ctrl u_ep (
			.clk_i        (clk_i),
			.rst_n_i      (rst_n_i),
			.ce_i         (ce_i),
			.wr_en_i      (ep_wr[i]),
			.wdata_i      (w_byte),
			.ctrl_o       (ep_ctl[i]),
			.stall_sent_i (stall_sent_i[i]),
			.setup_ok_o   (ep_setup_ok_o[i])
		);

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				ep_rx_en_o[i]        <= 1'b0;
				ep_tx_en_o[i]        <= 1'b0;
				ep_handshake_en_o[i] <= 1'b0;
			end else if (ce_i) begin
				ep_rx_en_o[i]        <= ep_ctl[i][`USBC_EP_RXEN];
				ep_tx_en_o[i]        <= ep_ctl[i][`USBC_EP_TXEN];
				ep_handshake_en_o[i] <= ep_ctl[i][`USBC_EP_HSHK];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------------------
	assign s_axi_arready_o = ce_i && !s_axi_rvalid_o;

	always_comb begin
		case (rd_sel)
			USBC_SEL_CFG: rd_byte = cfg;
			USBC_SEL_PWR: rd_byte = pwr;
			USBC_SEL_EP:  rd_byte = ep_ctl[rd_idx];
			default:      rd_byte = '0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= '0;
			s_axi_rresp_o  <= `USBC_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= {`USBC_HI_ZERO, rd_byte};
			s_axi_rresp_o  <= (rd_sel == USBC_SEL_NONE) ? `USBC_RESP_SLVERR
				: `USBC_RESP_OKAY;
		end else if (ce_i && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Module control outputs
	// ------------------------------------------------------------------------
	assign next_suspend = pwr[`USBC_PWR_SUSP] ||
		(cfg[`USBC_CFG_ASUSP] && sleep_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			eye_pattern_test_o     <= 1'b0;
			drive_enable_monitor_o <= 1'b0;
			module_halt_o          <= 1'b0;
			suspend_o              <= 1'b0;
			clk48_enable_o         <= 1'b1;
		end else if (ce_i) begin
			eye_pattern_test_o     <= cfg[`USBC_CFG_EYE];
			drive_enable_monitor_o <= cfg[`USBC_CFG_OEMON] && phy_drive_i;
			module_halt_o          <= cfg[`USBC_CFG_SIDL] && idle_i;
			suspend_o              <= next_suspend;
			clk48_enable_o         <= !next_suspend;
		end
	end

	// ------------------------------------------------------------------------
	// Host mode endpoint 0 control
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lowspeed_direct_o <= 1'b0;
			preamble_needed_o <= 1'b0;
			nak_retry_o       <= 1'b0;
		end else if (ce_i) begin
			lowspeed_direct_o <= host_mode_i && ep_ctl[0][`USBC_EP_LOWSPEED_DIRECT_EN];
			preamble_needed_o <= host_mode_i && !ep_ctl[0][`USBC_EP_LOWSPEED_DIRECT_EN];
			nak_retry_o       <= host_mode_i && !ep_ctl[0][`USBC_EP_NORETRY];
		end
	end

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking

	default disable iff (!rst_n_i);

	sequence s_stall_evt;
		ce_i && stall_sent_i[0];
	endsequence

	sequence s_cfg_write(int bitpos);
		wr_go && w_lane0 && wr_sel == USBC_SEL_CFG && w_byte[bitpos];
	endsequence

	read_upper_zero_a: assert property (
		s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == `USBC_HI_ZERO)
		else $error("read data above bit 7 not zero");

	eye_follows_a: assert property (
		s_cfg_write(`USBC_CFG_EYE) ##1 ce_i |=> eye_pattern_test_o)
		else $error("eye test not enabled after config write");

	oe_monitor_a: assert property (
		ce_i |=> drive_enable_monitor_o ==
			$past(cfg[`USBC_CFG_OEMON] && phy_drive_i))
		else $error("drive monitor does not follow enable and drive");

	idle_halt_a: assert property (
		ce_i && cfg[`USBC_CFG_SIDL] && idle_i |=> module_halt_o)
		else $error("module not halted in idle");

	auto_suspend_a: assert property (
		ce_i && cfg[`USBC_CFG_ASUSP] && sleep_i |=> suspend_o && !clk48_enable_o)
		else $error("no automatic suspend in sleep");

	sleep_no_suspend_a: assert property (
		ce_i && !cfg[`USBC_CFG_ASUSP] && !pwr[`USBC_PWR_SUSP] |=>
			!suspend_o && clk48_enable_o)
		else $error("suspended without software request");

	lowspeed_sel_a: assert property (
		ce_i && host_mode_i |=> lowspeed_direct_o != preamble_needed_o &&
			lowspeed_direct_o == $past(ep_ctl[0][`USBC_EP_LOWSPEED_DIRECT_EN]))
		else $error("low-speed route and preamble disagree");

	nak_retry_a: assert property (
		ce_i && host_mode_i |=> nak_retry_o == !$past(ep_ctl[0][`USBC_EP_NORETRY]))
		else $error("retry does not follow endpoint 0 bit 6");

	setup_gate_a: assert property (
		ce_i |=> ep_setup_ok_o[0] == $past(ep_ctl[0][`USBC_EP_RXEN] &&
			!(ep_ctl[0][`USBC_EP_CONDIS] && ep_ctl[0][`USBC_EP_TXEN])))
		else $error("setup acceptance wrong for endpoint 0");

	rx_tx_enable_a: assert property (
		ce_i |=> ep_rx_en_o[0] == $past(ep_ctl[0][`USBC_EP_RXEN]) &&
			ep_tx_en_o[0] == $past(ep_ctl[0][`USBC_EP_TXEN]))
		else $error("endpoint 0 enables do not follow register");

	stall_sticky_a: assert property (
		s_stall_evt |=> ep_ctl[0][`USBC_EP_STALL])
		else $error("stall flag not set after stall");

	handshake_en_a: assert property (
		ce_i |=> ep_handshake_en_o[0] == $past(ep_ctl[0][`USBC_EP_HSHK]))
		else $error("handshake enable does not follow register");

endmodule

/* File: usbc_params.svh */
`ifndef USBC_PARAMS_SVH
`define USBC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define USBC_OFS_CFG      8'h00
`define USBC_OFS_PWR      8'h04
`define USBC_OFS_EP_BASE  8'h40
`define USBC_EP_IDX_LSB   2
`define USBC_EP_IDX_W     4

// ----------------------------------------------------------------------------
// General configuration fields
// ----------------------------------------------------------------------------
`define USBC_CFG_EYE      7
`define USBC_CFG_OEMON    6
`define USBC_CFG_SIDL     4
`define USBC_CFG_ASUSP    0
`define USBC_CFG_WMASK    8'hd1
`define USBC_CFG_RESET    8'h00

// ----------------------------------------------------------------------------
// Power control fields
// ----------------------------------------------------------------------------
`define USBC_PWR_SUSP     1
`define USBC_PWR_WMASK    8'h02
`define USBC_PWR_RESET    8'h00

// ----------------------------------------------------------------------------
// Endpoint control fields
// ----------------------------------------------------------------------------
`define USBC_EP_LOWSPEED_DIRECT_EN      7
`define USBC_EP_NORETRY   6
`define USBC_EP_CONDIS    4
`define USBC_EP_RXEN      3
`define USBC_EP_TXEN      2
`define USBC_EP_STALL     1
`define USBC_EP_HSHK      0
`define USBC_EP_WMASK     8'hdd
`define USBC_EP_RESET     8'h00

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define USBC_RESP_OKAY    2'b00
`define USBC_RESP_SLVERR  2'b10
`define USBC_HI_ZERO      24'h000000

`endif

/* File: usbc_pkg.sv */
package usbc_pkg;

	typedef logic [7:0]  usbc_reg8_t;
	typedef logic [31:0] usbc_word_t;

	typedef enum logic [1:0] {
		USBC_SEL_CFG,
		USBC_SEL_PWR,
		USBC_SEL_EP,
		USBC_SEL_NONE
	} usbc_sel_t;

endpackage

/* File: usbc_ep_ctrl.sv */
`timescale 1ns/1ps
`include "usbc_params.svh"

module usbc_ep_ctrl
	import usbc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	// Register access
	input  wire logic       wr_en_i,
	input  wire usbc_reg8_t wdata_i,
	output usbc_reg8_t      ctrl_o,
	// Engine side
	input  wire logic       stall_sent_i,
	output logic            setup_ok_o
);

	usbc_reg8_t ctrl;
	logic       stalled;

	// ------------------------------------------------------------------------
	// Software fields
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= `USBC_EP_RESET;
		end else if (ce_i && wr_en_i) begin
			ctrl <= wdata_i & `USBC_EP_WMASK;
		end
	end

	// ------------------------------------------------------------------------
	// Sticky stall flag, set wins over clear
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stalled <= 1'b0;
		end else if (ce_i) begin
			if (stall_sent_i) begin
				stalled <= 1'b1;
			end else if (wr_en_i && !wdata_i[`USBC_EP_STALL]) begin
				stalled <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Setup acceptance
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			setup_ok_o <= 1'b0;
		end else if (ce_i) begin
			setup_ok_o <= ctrl[`USBC_EP_RXEN] && !(ctrl[`USBC_EP_CONDIS] &&
				ctrl[`USBC_EP_TXEN] && ctrl[`USBC_EP_RXEN]);
		end
	end

	always_comb begin
		ctrl_o                 = ctrl;
		ctrl_o[`USBC_EP_STALL] = stalled;
	end

endmodule

/* File: usbc_engine_model.sv */
`timescale 1ns/1ps

module usbc_engine_model #(
	parameter int NUM_EP = 16
) (
	// Clock
	input  wire logic         clk_i,
	// Power manager and engine status
	output logic              idle_o,
	output logic              sleep_o,
	output logic              host_mode_o,
	output logic              phy_drive_o,
	output logic [NUM_EP-1:0] stall_sent_o
);
	initial begin
		idle_o = 1'b0;
		sleep_o = 1'b0;
		host_mode_o = 1'b0;
		phy_drive_o = 1'b0;
		stall_sent_o = '0;
	end

	// Levels in order idle, sleep, host mode, line drive
	task automatic set_levels(input logic [3:0] lv);
		@(posedge clk_i);
		{idle_o, sleep_o, host_mode_o, phy_drive_o} <= lv;
	endtask

	// One cycle pulse as the engine answers with STALL
	task automatic send_stall(input int ep);
		@(posedge clk_i);
		stall_sent_o[ep] <= 1'b1;
		@(posedge clk_i);
		stall_sent_o <= '0;
	endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
`include "usbc_params.svh"

module testbench
	import usbc_pkg::*;
;
	logic        clk_i, rst_n_i, ce_i;
	logic        awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
	logic [7:0]  awa, ara;
	logic [3:0]  wst;
	logic [1:0]  bresp, rresp, r;
	usbc_word_t  wd, rd, d;
	logic        idle, sleep, host, phy, eye, mon, halt, susp, c48, lsd, pre, nak;
	logic [15:0] stall, rx, tx, sok, hs, ex_rx, ex_tx, ex_sok, ex_hs;
	logic [7:0]  p;
	logic [7:0]  pat [4] = '{8'h1d, 8'h0c, 8'h18, 8'h14};
	int          err_count, num_checks;

	usbc_cfg_ep usbc_cfg_ep_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(wst), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
		.s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
		.s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
		.idle_i(idle), .sleep_i(sleep), .host_mode_i(host), .phy_drive_i(phy),
		.stall_sent_i(stall), .eye_pattern_test_o(eye), .drive_enable_monitor_o(mon),
		.module_halt_o(halt), .suspend_o(susp), .clk48_enable_o(c48),
		.lowspeed_direct_o(lsd), .preamble_needed_o(pre), .nak_retry_o(nak),
		.ep_rx_en_o(rx), .ep_tx_en_o(tx), .ep_setup_ok_o(sok), .ep_handshake_en_o(hs)
	);

	usbc_engine_model usbc_engine_model_inst (
		.clk_i(clk_i), .idle_o(idle), .sleep_o(sleep), .host_mode_o(host),
		.phy_drive_o(phy), .stall_sent_o(stall)
	);

	// ------------------------------------------------------------------
	// Bus and checking tasks
	// ------------------------------------------------------------------
	task automatic complete_run;
		if (err_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input usbc_word_t seen, input usbc_word_t exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic bound(input int n);
		if (n > 50) begin
			err_count++;
			complete_run();
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic axi_wr(input logic [7:0] a, input usbc_word_t v, output logic [1:0] rs);
		int  n;
		logic aw, w;
		@(posedge clk_i);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		while (aw || w) begin
			@(posedge clk_i);
			if (aw && awr === 1'b1) begin
				aw = 1'b0;
				awv <= 1'b0;
			end
			if (w && wr_rdy === 1'b1) begin
				w = 1'b0;
				wv <= 1'b0;
			end
			bound(++n);
		end
		while (bv !== 1'b1) begin
			@(posedge clk_i);
			bound(++n);
		end
		rs = bresp;
		br <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output usbc_word_t v, output logic [1:0] rs);
		int n;
		@(posedge clk_i);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			bound(++n);
		end while (arr !== 1'b1);
		arv <= 1'b0;
		while (rv !== 1'b1) begin
			@(posedge clk_i);
			bound(++n);
		end
		v = rd;
		rs = rresp;
		rr <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input usbc_word_t v);
		axi_wr(a, v, r);
		check(r, `USBC_RESP_OKAY);
	endtask

	task automatic rd_chk(input logic [7:0] a, input usbc_word_t e);
		axi_rd(a, d, r);
		check(d, e);
		check(r, `USBC_RESP_OKAY);
	endtask

	// ------------------------------------------------------------------
	// Clock and sequence
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		{rst_n_i, awv, wv, br, arv, rr, awa, ara, wd} = '0;
		ce_i = 1'b1;
		wst = 4'hf;
		err_count = 0;
		num_checks = 0;
		tick(6);
		rst_n_i <= 1'b1;
		tick(1);
		check(c48, 1'b1);
		rd_chk(`USBC_OFS_CFG, 32'h0);
		rd_chk(`USBC_OFS_EP_BASE + 8'h3c, 32'h0);
		usbc_engine_model_inst.set_levels(4'b1101);
		wr(`USBC_OFS_CFG, 32'hffffffff);
		rd_chk(`USBC_OFS_CFG, 32'hd1);
		tick(3);
		check(eye, 1'b1);
		check(mon, 1'b1);
		check(halt, 1'b1);
		check({susp, c48}, 2'b10);
		usbc_engine_model_inst.set_levels(4'b0000);
		tick(3);
		check({mon, halt, susp}, 3'b000);
		usbc_engine_model_inst.set_levels(4'b1101);
		wr(`USBC_OFS_CFG, 32'h0);
		tick(3);
		check({eye, mon, halt}, 3'b000);
		check({susp, c48}, 2'b01);
		wr(`USBC_OFS_PWR, 32'h2);
		tick(3);
		check({susp, c48}, 2'b10);
		wr(`USBC_OFS_PWR, 32'h0);
		// Endpoint enables across every endpoint
		for (int i = 0; i < 16; i++) begin
			p = pat[i % 4];
			wr(`USBC_OFS_EP_BASE + 8'(4 * i), {24'hffffff, p});
			ex_rx[i] = p[3];
			ex_tx[i] = p[2];
			ex_hs[i] = p[0];
			ex_sok[i] = p[3] & ~(p[4] & p[2]);
		end
		for (int i = 0; i < 16; i++) begin
			rd_chk(`USBC_OFS_EP_BASE + 8'(4 * i), {24'h0, pat[i % 4] & 8'hdd});
		end
		check(rx, ex_rx);
		check(tx, ex_tx);
		check(hs, ex_hs);
		check(sok, ex_sok);
		// Host mode controls on endpoint 0
		usbc_engine_model_inst.set_levels(4'b0010);
		wr(`USBC_OFS_EP_BASE, 32'h80);
		tick(3);
		check({lsd, pre}, 2'b10);
		check(nak, 1'b1);
		wr(`USBC_OFS_EP_BASE, 32'h40);
		tick(3);
		check({lsd, pre}, 2'b01);
		check(nak, 1'b0);
		// Stall on endpoint 0 sets its sticky flag
		usbc_engine_model_inst.send_stall(0);
		tick(2);
		rd_chk(`USBC_OFS_EP_BASE, 32'h42);
		// Stall flag set by engine, cleared only by writing zero
		usbc_engine_model_inst.send_stall(5);
		tick(2);
		rd_chk(`USBC_OFS_EP_BASE + 8'h14, 32'h0e);
		rd_chk(`USBC_OFS_EP_BASE + 8'h10, 32'h1d);
		wr(`USBC_OFS_EP_BASE + 8'h14, 32'h0e);
		rd_chk(`USBC_OFS_EP_BASE + 8'h14, 32'h0e);
		wr(`USBC_OFS_EP_BASE + 8'h14, 32'h0c);
		rd_chk(`USBC_OFS_EP_BASE + 8'h14, 32'h0c);
		// Unmapped places answer with an error and read zero
		axi_wr(8'h08, 32'hff, r);
		check(r, `USBC_RESP_SLVERR);
		axi_rd(8'h80, d, r);
		check(d, 32'h0);
		check(r, `USBC_RESP_SLVERR);
		// Lane 0 strobe low leaves the register alone
		wst <= 4'he;
		wr(`USBC_OFS_CFG, 32'hff);
		wst <= 4'hf;
		rd_chk(`USBC_OFS_CFG, 32'h0);
		// Clock enable low holds the bus off
		ce_i <= 1'b0;
		tick(2);
		check({awr, wr_rdy, arr}, 3'b000);
		ce_i <= 1'b1;
		tick(2);
		complete_run();
	end
endmodule
